/* include/dnp_defines.svh */
// constants for the outstation request handler: header bits, codes, scales, register map
`ifndef DNP_DEFINES_SVH
`define DNP_DEFINES_SVH
`define TH_FIN_BIT 7
`define TH_FIR_BIT 6
`define AC_FIR_BIT 7
`define AC_FIN_BIT 6
`define AC_CON_BIT 5
`define RESP_TH 8'hC0
`define RESP_AC 8'hC0
`define FC_READ 8'h01
`define FC_WRITE 8'h02
`define FC_DOP 8'h05
`define FC_DOP_NA 8'h06
`define FC_RESP 8'h81
`define GRP_BO 8'h0A
`define GRP_CROB 8'h0C
`define GRP_CNT 8'h14
`define GRP_AI 8'h1E
`define GRP_CLASS 8'h3C
`define GRP_IIN 8'h50
`define VAR_ANY 8'h00
`define VAR_BO 8'h02
`define VAR_CROB 8'h01
`define VAR_CNT 8'h05
`define VAR_AI 8'h04
`define VAR_CLASS0 8'h01
`define VAR_IIN 8'h01
`define QUAL_RANGE8 8'h00
`define QUAL_ALL 8'h06
`define QUAL_CNT_IDX 8'h17
`define NUM_BO 8'h02
`define NUM_CNT 8'h05
`define NUM_AI 8'h20
`define CROB_CODE_PULSE_ON 8'h01
`define CROB_COUNT_ONE 8'h01
`define CROB_ON_MS 32'h0000_0001
`define CROB_OFF_MS 32'h0000_0000
`define CROB_PT_ERST 8'h00
`define CROB_PT_MODBUS 8'h01
`define CROB_LEN 6'h13
`define WR_IIN_LEN 6'h09
`define ECHO_FIRST 5'h03
`define ECHO_LAST 5'h0F
`define HDR_LAST 5'h04
`define FS_POS 20'sh07FFF
`define FS_NEG 20'shF8001
`define PF_MAX 16'sh03E8
`define PF_MIN 16'shFC18
`define FREQ_LO 16'h1194
`define FREQ_HI 16'h1D4C
`define FREQ_PIN 16'h270F
`define IIN1_RESTART_BIT 7
`define IIN2_NO_FUNC_BIT 0
`define IIN2_OBJ_UNK_BIT 1
`define REQ_DEPTH 32
`define ERST_CYCLES 3'h4
`define REG_CTRL 8'h00
`define REG_STATUS 8'h04
`define REG_REJECT 8'h08
`define AUX_FIRST_PT 5'h0F
`endif

/* include/dnp_pkg.sv */
// types shared by the outstation request handler
package dnp_pkg;
    typedef enum logic [2:0] {ST_IDLE, ST_RX, ST_EXEC, ST_HDR, ST_OHDR, ST_DATA, ST_ECHO} state_t;
endpackage : dnp_pkg

/* rtl/dnp_outstation_points.sv */
// outstation request handler: parses one request frame, acts on it, streams the response
//
// The implementer's own choices: register access over Wishbone and the register offsets.
`timescale 1ns/1ps
`include "dnp_defines.svh"
module dnp_outstation_points (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [7:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o,
    input wire logic req_valid_i,
    input wire logic [7:0] req_data_i,
    input wire logic req_last_i,
    output logic req_ready_o,
    input wire logic resp_ready_i,
    output logic resp_valid_o,
    output logic [7:0] resp_data_o,
    output logic resp_last_o,
    input wire logic [4:0] energy_inc_i,
    input wire logic [15:0] health_i,
    input wire logic signed [2:0][17:0] vln_i,
    input wire logic signed [2:0][17:0] vll_i,
    input wire logic signed [2:0][17:0] iph_i,
    input wire logic signed [2:0][17:0] pwr_i,
    input wire logic signed [15:0] pf_i,
    input wire logic [15:0] freq_i,
    output logic proto_modbus_o,
    output logic energy_clearing_o
);
    dnp_pkg::state_t st_q, st_d;
    logic [7:0] req_q [0:`REQ_DEPTH-1];
    logic [5:0] rx_len_q;
    logic ovf_q;
    logic [31:0] cnt_q [0:4];
    logic [15:0] aux_q [0:31];
    logic [2:0] erst_q;
    logic modbus_q, restart_q, open_delta_q;
    logic [15:0] reject_q;
    logic [7:0] blk_grp_q [0:2];
    logic [7:0] blk_start_q [0:2];
    logic [7:0] blk_stop_q [0:2];
    logic [1:0] blk_q, nblk_q;
    logic echo_q;
    logic [7:0] iin2_q, seq_q;
    logic [4:0] pos_q;
    logic [7:0] pt_q;
    logic [1:0] bpos_q;
    logic [7:0] oidx_q;

    function automatic logic [7:0] fixed_var(input logic [7:0] g);
        return (g == `GRP_BO) ? `VAR_BO : (g == `GRP_CNT) ? `VAR_CNT : `VAR_AI;
    endfunction : fixed_var

    function automatic logic [7:0] num_pts(input logic [7:0] g);
        return (g == `GRP_BO) ? `NUM_BO : (g == `GRP_CNT) ? `NUM_CNT : `NUM_AI;
    endfunction : num_pts

    function automatic logic [1:0] last_byte(input logic [7:0] g);
        return (g == `GRP_BO) ? 2'h0 : (g == `GRP_CNT) ? 2'h3 : 2'h1;
    endfunction : last_byte

    // clamp to the symmetric two's complement full scale
    function automatic logic [15:0] sat16(input logic signed [19:0] x);
        if (x > `FS_POS) begin
            return 16'(`FS_POS);
        end else if (x < `FS_NEG) begin
            return 16'(`FS_NEG);
        end
        return x[15:0];
    endfunction : sat16

    // analog point values
    logic [15:0] ai_pt [0:31];
    logic signed [15:0] pf_clip;
    assign ai_pt[0] = health_i;
    genvar gi;
    generate
        for (gi = 0; gi < 3; gi++) begin : g_phase
            logic signed [19:0] pw_n, pw_od;
            assign pw_n = {{2{pwr_i[gi][17]}}, pwr_i[gi]};
            // open-delta full scale is two thirds, so the fraction grows by 3/2
            assign pw_od = (pw_n + (pw_n <<< 1)) >>> 1;
            assign ai_pt[1+gi] = sat16({{2{vln_i[gi][17]}}, vln_i[gi]});
            assign ai_pt[4+gi] = sat16({{2{vll_i[gi][17]}}, vll_i[gi]});
            assign ai_pt[7+gi] = sat16({{2{iph_i[gi][17]}}, iph_i[gi]});
            assign ai_pt[10+gi] = sat16(open_delta_q ? pw_od : pw_n);
        end
        for (gi = 15; gi < 32; gi++) begin : g_aux
            assign ai_pt[gi] = aux_q[gi];
        end
    endgenerate
    assign pf_clip = (pf_i > `PF_MAX) ? `PF_MAX : (pf_i < `PF_MIN) ? `PF_MIN : pf_i;
    assign ai_pt[13] = open_delta_q ? 16'h0000 : pf_clip;
    assign ai_pt[14] = (freq_i < `FREQ_LO) ? 16'h0000 : (freq_i > `FREQ_HI) ? `FREQ_PIN : freq_i;

    // request decode
    logic [7:0] r_th, r_ac, r_fc, r_grp, r_var, r_qual, r_a, r_b;
    logic fr_ok, is_read, is_write, is_dop, is_dopna, fn_known;
    logic rd_grp_ok, rd_var_ok, rd_rng_ok, rd_single_ok, rd_class_ok, wr_ok;
    logic crob_hdr_ok, crob_par_ok, act, act_erst, act_modbus, req_ok, respond, exec;
    assign r_th = req_q[0];
    assign r_ac = req_q[1];
    assign r_fc = req_q[2];
    assign r_grp = req_q[3];
    assign r_var = req_q[4];
    assign r_qual = req_q[5];
    assign r_a = req_q[6];
    assign r_b = req_q[7];
    assign exec = (st_q == dnp_pkg::ST_EXEC);
    logic [5:0] wr_idx;
    // length restarts with the first byte, so it still stands at execute
    assign wr_idx = (st_q == dnp_pkg::ST_IDLE) ? 6'h00 : rx_len_q;
    assign fr_ok = r_th[`TH_FIR_BIT] & r_th[`TH_FIN_BIT] & r_ac[`AC_FIR_BIT] & r_ac[`AC_FIN_BIT]
                   & !ovf_q & (rx_len_q >= 6'h03);
    assign is_read = (r_fc == `FC_READ);
    assign is_write = (r_fc == `FC_WRITE);
    assign is_dop = (r_fc == `FC_DOP);
    assign is_dopna = (r_fc == `FC_DOP_NA);
    assign fn_known = is_read | is_write | is_dop | is_dopna;
    assign rd_grp_ok = (r_grp == `GRP_BO) | (r_grp == `GRP_CNT) | (r_grp == `GRP_AI);
    // variation zero or the fixed one
    assign rd_var_ok = (r_var == `VAR_ANY) | (r_var == fixed_var(r_grp));
    assign rd_rng_ok = (r_qual == `QUAL_ALL) | ((r_qual == `QUAL_RANGE8) & (r_b >= r_a) & (r_b < num_pts(r_grp)));
    assign rd_single_ok = is_read & rd_grp_ok & rd_var_ok & rd_rng_ok;
    assign rd_class_ok = is_read & (r_grp == `GRP_CLASS) & ((r_var == `VAR_ANY) | (r_var == `VAR_CLASS0));
    assign wr_ok = is_write & (r_grp == `GRP_IIN) & (r_var == `VAR_IIN) & (r_qual == `QUAL_RANGE8)
                   & (r_a == 8'h00) & (r_b == 8'h00) & (rx_len_q >= `WR_IIN_LEN);
    assign crob_hdr_ok = (is_dop | is_dopna) & (r_grp == `GRP_CROB) & (r_var == `VAR_CROB)
                         & (r_qual == `QUAL_CNT_IDX) & (r_a == 8'h01) & (rx_len_q >= `CROB_LEN);
    // only pulse-on, once, 1 ms on, 0 ms off
    assign crob_par_ok = (req_q[8] == `CROB_CODE_PULSE_ON) & (req_q[9] == `CROB_COUNT_ONE)
                         & ({req_q[13], req_q[12], req_q[11], req_q[10]} == `CROB_ON_MS)
                         & ({req_q[17], req_q[16], req_q[15], req_q[14]} == `CROB_OFF_MS);
    assign act = exec & fr_ok & crob_hdr_ok & crob_par_ok;
    // point 0 clears energy, point 1 switches protocol
    assign act_erst = act & (r_b == `CROB_PT_ERST);
    assign act_modbus = act & (r_b == `CROB_PT_MODBUS);
    assign req_ok = rd_single_ok | rd_class_ok | wr_ok | crob_hdr_ok;
    assign respond = fr_ok & !is_dopna;

    // response byte selection
    logic [7:0] cur_grp, cur_byte, bo_byte;
    logic out_free, emitting, blk_end, at_end;
    assign cur_grp = blk_grp_q[blk_q];
    // energy reset state; relay open while DNP is active
    assign bo_byte = {(pt_q == 8'h00) ? (erst_q != 3'h0) : !modbus_q, 6'h00, 1'b1};
    assign out_free = !resp_valid_o | resp_ready_i;
    assign emitting = (st_q == dnp_pkg::ST_HDR) | (st_q == dnp_pkg::ST_OHDR)
                      | (st_q == dnp_pkg::ST_DATA) | (st_q == dnp_pkg::ST_ECHO);
    assign blk_end = (bpos_q == last_byte(cur_grp)) & (pt_q == blk_stop_q[blk_q]);
    assign at_end = ((st_q == dnp_pkg::ST_HDR) & (pos_q == `HDR_LAST) & (nblk_q == 2'h0) & !echo_q)
                    | ((st_q == dnp_pkg::ST_DATA) & blk_end & (blk_q + 2'h1 == nblk_q))
                    | ((st_q == dnp_pkg::ST_ECHO) & (pos_q == `ECHO_LAST));
    always_comb begin
        cur_byte = 8'h00;
        unique case (st_q)
            dnp_pkg::ST_HDR: begin
                if (pos_q == 5'h00) cur_byte = `RESP_TH;
                else if (pos_q == 5'h01) cur_byte = `RESP_AC | {4'h0, seq_q[3:0]};
                else if (pos_q == 5'h02) cur_byte = `FC_RESP;
                else if (pos_q == 5'h03) cur_byte = {restart_q, 7'h00};
                else cur_byte = iin2_q;
            end
            dnp_pkg::ST_OHDR: begin
                if (pos_q == 5'h00) cur_byte = cur_grp;
                else if (pos_q == 5'h01) cur_byte = fixed_var(cur_grp);
                else if (pos_q == 5'h02) cur_byte = `QUAL_RANGE8;
                else if (pos_q == 5'h03) cur_byte = blk_start_q[blk_q];
                else cur_byte = blk_stop_q[blk_q];
            end
            dnp_pkg::ST_DATA: begin
                if (cur_grp == `GRP_BO) cur_byte = bo_byte;
                else if (cur_grp == `GRP_CNT) cur_byte = cnt_q[pt_q[2:0]][{bpos_q, 3'h0} +: 8];
                else cur_byte = ai_pt[pt_q[4:0]][{bpos_q[0], 3'h0} +: 8];
            end
            dnp_pkg::ST_ECHO: cur_byte = req_q[pos_q + `ECHO_FIRST];
            default: cur_byte = 8'h00;
        endcase
    end

    // next state
    always_comb begin
        st_d = st_q;
        unique case (st_q)
            dnp_pkg::ST_IDLE, dnp_pkg::ST_RX: begin
                if (req_valid_i && req_ready_o) st_d = req_last_i ? dnp_pkg::ST_EXEC : dnp_pkg::ST_RX;
            end
            // bad framing is dropped silently; no-acknowledge operate has no reply
            dnp_pkg::ST_EXEC: st_d = respond ? dnp_pkg::ST_HDR : dnp_pkg::ST_IDLE;
            dnp_pkg::ST_HDR: begin
                if (out_free && pos_q == `HDR_LAST) begin
                    st_d = (nblk_q != 2'h0) ? dnp_pkg::ST_OHDR : echo_q ? dnp_pkg::ST_ECHO : dnp_pkg::ST_IDLE;
                end
            end
            dnp_pkg::ST_OHDR: if (out_free && pos_q == `HDR_LAST) st_d = dnp_pkg::ST_DATA;
            dnp_pkg::ST_DATA: begin
                if (out_free && blk_end) st_d = (blk_q + 2'h1 == nblk_q) ? dnp_pkg::ST_IDLE : dnp_pkg::ST_OHDR;
            end
            dnp_pkg::ST_ECHO: if (out_free && pos_q == `ECHO_LAST) st_d = dnp_pkg::ST_IDLE;
        endcase
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            st_q <= dnp_pkg::ST_IDLE;
            req_ready_o <= 1'b0;
            rx_len_q <= 6'h00;
            ovf_q <= 1'b0;
        end else begin
            st_q <= st_d;
            req_ready_o <= (st_d == dnp_pkg::ST_IDLE) | (st_d == dnp_pkg::ST_RX);
            if (req_valid_i && req_ready_o) begin
                if (wr_idx < `REQ_DEPTH) req_q[wr_idx[4:0]] <= req_data_i;
                ovf_q <= (wr_idx >= `REQ_DEPTH) | ((st_q == dnp_pkg::ST_RX) & ovf_q);
                rx_len_q <= (wr_idx < `REQ_DEPTH) ? wr_idx + 6'h01 : wr_idx;
            end
        end
    end

    // response plan captured at execute
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            nblk_q <= 2'h0;
            echo_q <= 1'b0;
            iin2_q <= 8'h00;
            seq_q <= 8'h00;
        end else if (exec) begin
            seq_q <= r_ac;
            echo_q <= crob_hdr_ok & is_dop;
            iin2_q <= 8'h00;
            iin2_q[`IIN2_NO_FUNC_BIT] <= !fn_known;
            iin2_q[`IIN2_OBJ_UNK_BIT] <= fn_known & !req_ok;
            nblk_q <= rd_class_ok ? 2'h3 : {1'b0, rd_single_ok};
            // class 0 order analog, counters, binary
            blk_grp_q[0] <= rd_class_ok ? `GRP_AI : r_grp;
            blk_grp_q[1] <= `GRP_CNT;
            blk_grp_q[2] <= `GRP_BO;
            blk_start_q[0] <= (rd_class_ok || r_qual == `QUAL_ALL) ? 8'h00 : r_a;
            blk_start_q[1] <= 8'h00;
            blk_start_q[2] <= 8'h00;
            blk_stop_q[0] <= rd_class_ok ? `NUM_AI - 8'h01 : (r_qual == `QUAL_ALL) ? num_pts(r_grp) - 8'h01 : r_b;
            blk_stop_q[1] <= `NUM_CNT - 8'h01;
            blk_stop_q[2] <= `NUM_BO - 8'h01;
        end
    end

    // byte walker and output register
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            resp_valid_o <= 1'b0;
            resp_data_o <= 8'h00;
            resp_last_o <= 1'b0;
            pos_q <= 5'h00;
            pt_q <= 8'h00;
            bpos_q <= 2'h0;
            blk_q <= 2'h0;
        end else if (exec) begin
            pos_q <= 5'h00;
            blk_q <= 2'h0;
        end else if (emitting && out_free) begin
            resp_valid_o <= 1'b1;
            resp_data_o <= cur_byte;
            resp_last_o <= at_end;
            // data bytes leave pos_q at zero for the next object header
            if (st_q != dnp_pkg::ST_DATA) begin
                pos_q <= (pos_q == `HDR_LAST && st_q != dnp_pkg::ST_ECHO) ? 5'h00 : pos_q + 5'h01;
            end
            if (st_q == dnp_pkg::ST_OHDR) begin
                pt_q <= blk_start_q[blk_q];
                bpos_q <= 2'h0;
            end else if (st_q == dnp_pkg::ST_DATA) begin
                bpos_q <= (bpos_q == last_byte(cur_grp)) ? 2'h0 : bpos_q + 2'h1;
                if (bpos_q == last_byte(cur_grp)) pt_q <= pt_q + 8'h01;
                if (blk_end) blk_q <= blk_q + 2'h1;
            end
        end else if (resp_ready_i) begin
            resp_valid_o <= 1'b0;
            resp_last_o <= 1'b0;
        end
    end

    // energy accumulation and protocol state
    logic erst_busy;
    assign erst_busy = (erst_q != 3'h0);
    generate
        for (gi = 0; gi < 5; gi++) begin : g_cnt
            always_ff @(posedge clk_i) begin
                if (rst_i || erst_busy) cnt_q[gi] <= 32'h0000_0000;
                else if (energy_inc_i[gi]) cnt_q[gi] <= cnt_q[gi] + 32'h0000_0001;
            end
        end
    endgenerate
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            erst_q <= 3'h0;
            modbus_q <= 1'b0;
            restart_q <= 1'b1;
            reject_q <= 16'h0000;
            proto_modbus_o <= 1'b0;
            energy_clearing_o <= 1'b0;
        end else begin
            // clearing holds counters for a few cycles
            if (act_erst) erst_q <= `ERST_CYCLES;
            else if (erst_busy) erst_q <= erst_q - 3'h1;
            // only the active protocol moves; reset brings back DNP
            if (act_modbus) modbus_q <= 1'b1;
            // write of zero to point 0 clears restart
            if (exec && fr_ok && wr_ok && !req_q[8][0]) restart_q <= 1'b0;
            if (exec && (!fr_ok || !req_ok)) reject_q <= reject_q + 16'h0001;
            proto_modbus_o <= modbus_q | act_modbus;
            energy_clearing_o <= act_erst | (erst_q > 3'h1);
        end
    end

    // classic wishbone slave, one wait state
    logic [31:0] rd_word;
    logic wb_req, aux_hit;
    assign wb_req = wb_cyc_i & wb_stb_i & !wb_ack_o;
    assign aux_hit = wb_adr_i[7] & (wb_adr_i[6:2] >= `AUX_FIRST_PT);
    assign rd_word = (wb_adr_i == `REG_CTRL) ? {31'h0, open_delta_q}
                   : (wb_adr_i == `REG_STATUS) ? {28'h0, modbus_q, erst_busy, restart_q, 1'b0}
                   : (wb_adr_i == `REG_REJECT) ? {16'h0, reject_q}
                   : aux_hit ? {16'h0, aux_q[wb_adr_i[6:2]]} : 32'h0000_0000;
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            wb_ack_o <= 1'b0;
            wb_dat_o <= 32'h0000_0000;
            open_delta_q <= 1'b0;
        end else begin
            wb_ack_o <= wb_req;
            wb_dat_o <= (wb_req && !wb_we_i) ? rd_word : 32'h0000_0000;
            if (wb_req && wb_we_i && wb_adr_i == `REG_CTRL && wb_sel_i[0]) open_delta_q <= wb_dat_i[0];
            if (wb_req && wb_we_i && aux_hit) begin
                if (wb_sel_i[0]) aux_q[wb_adr_i[6:2]][7:0] <= wb_dat_i[7:0];
                if (wb_sel_i[1]) aux_q[wb_adr_i[6:2]][15:8] <= wb_dat_i[15:8];
            end
        end
    end

    // checks; oidx_q counts accepted response bytes within a frame
    always_ff @(posedge clk_i) begin
        if (rst_i) oidx_q <= 8'h00;
        else if (resp_valid_o && resp_ready_i) oidx_q <= resp_last_o ? 8'h00 : oidx_q + 8'h01;
    end
    property p_resp_func;
        @(posedge clk_i) disable iff (rst_i) resp_valid_o && oidx_q == 8'h02 |-> resp_data_o == `FC_RESP;
    endproperty
    a_resp_func: assert property (p_resp_func) else $error("reply function code wrong");
    property p_no_confirm;
        @(posedge clk_i) disable iff (rst_i)
        resp_valid_o && oidx_q == 8'h01
        |-> !resp_data_o[`AC_CON_BIT] && resp_data_o[`AC_FIR_BIT] && resp_data_o[`AC_FIN_BIT];
    endproperty
    a_no_confirm: assert property (p_no_confirm) else $error("reply control field wrong");
    sequence s_clearing;
        erst_busy [*4] ##1 !erst_busy;
    endsequence
    property p_erst_window;
        @(posedge clk_i) disable iff (rst_i) act_erst |=> s_clearing;
    endproperty
    a_erst_window: assert property (p_erst_window) else $error("energy reset window wrong");
    property p_cnt_clear;
        @(posedge clk_i) disable iff (rst_i) act_erst |=> ##2 cnt_q[0] == 32'h0 && cnt_q[4] == 32'h0;
    endproperty
    a_cnt_clear: assert property (p_cnt_clear) else $error("counters not cleared");
    property p_modbus;
        @(posedge clk_i) disable iff (rst_i) act_modbus |=> ##1 proto_modbus_o && modbus_q;
    endproperty
    a_modbus: assert property (p_modbus) else $error("protocol switch missing");
    property p_reject_still;
        @(posedge clk_i) disable iff (rst_i) exec && !fr_ok |=> $stable(modbus_q) && $stable(restart_q) && !erst_busy;
    endproperty
    a_reject_still: assert property (p_reject_still) else $error("rejected request changed state");
    property p_pf_od;
        @(posedge clk_i) disable iff (rst_i) open_delta_q |-> ai_pt[13] == 16'h0000;
    endproperty
    a_pf_od: assert property (p_pf_od) else $error("power factor not zero in open delta");
    property p_freq_pin;
        @(posedge clk_i) disable iff (rst_i) freq_i > `FREQ_HI |-> ai_pt[14] == `FREQ_PIN;
    endproperty
    a_freq_pin: assert property (p_freq_pin) else $error("frequency not pinned high");
    property p_restart_clr;
        @(posedge clk_i) disable iff (rst_i) exec && fr_ok && wr_ok && !req_q[8][0] |=> !restart_q;
    endproperty
    a_restart_clr: assert property (p_restart_clr) else $error("restart bit not cleared");
endmodule : dnp_outstation_points

/* verif/dnp_master_model.sv */
// polling master model: sends a request frame and gathers the reply
`timescale 1ns/1ps
module dnp_master_model (
    input wire logic clk_i,
    input wire logic req_ready_i,
    output logic req_valid_o = 1'b0,
    output logic [7:0] req_data_o = 8'h00,
    output logic req_last_o = 1'b0,
    input wire logic resp_valid_i,
    input wire logic [7:0] resp_data_i,
    input wire logic resp_last_i,
    output logic resp_ready_o = 1'b0
);
    logic [7:0] tx_q[$];
    logic [7:0] rx_q[$];
    // one unconfirmed single-frame request at a time
    task automatic xfer(input bit slow);
        rx_q = {};
        foreach (tx_q[i]) begin
            {req_valid_o, req_last_o, req_data_o} <= {1'b1, i == tx_q.size() - 1, tx_q[i]};
            do @(posedge clk_i); while (req_ready_i !== 1'b1);
        end
        // released byte inverted so a stale value is never reused
        {req_valid_o, req_last_o, req_data_o} <= {2'b00, ~req_data_o};
        for (int c = 0; c < 400; c++) begin
            resp_ready_o <= slow ? c[0] : 1'b1;
            @(posedge clk_i);
            if (resp_valid_i === 1'b1 && resp_ready_o === 1'b1) begin
                rx_q.push_back(resp_data_i);
                if (resp_last_i === 1'b1) break;
            end
        end
        resp_ready_o <= 1'b0;
    endtask : xfer
endmodule : dnp_master_model

/* verif/tb.sv */
// bench for the outstation request handler
`timescale 1ns/1ps
module tb;
    logic clk = 1'b0, rst = 1'b1, cyc = 1'b0, stb = 1'b0, we = 1'b0, ack, pm, ec, clr = 1'b0;
    logic [7:0] adr = 8'h00, qd, sd;
    logic [31:0] wd = 32'h0, rd, q, n;
    logic [4:0] inc = 5'h00;
    logic signed [2:0][17:0] vln = '0, pwr = '0;
    logic signed [15:0] pf = 16'sh0000;
    logic [15:0] fr = 16'h0000;
    logic qv, ql, qr, sv, sl, sr;
    int err_count = 0, n_checks = 0;
    initial forever #10 clk = ~clk;
    always @(posedge clk) if (ec) clr <= 1'b1;
    dnp_outstation_points i_dnp_outstation_points (.clk_i(clk), .rst_i(rst), .wb_cyc_i(cyc), .wb_stb_i(stb),
        .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'hF), .wb_dat_i(wd), .wb_dat_o(rd), .wb_ack_o(ack),
        .req_valid_i(qv), .req_data_i(qd), .req_last_i(ql), .req_ready_o(qr), .resp_ready_i(sr),
        .resp_valid_o(sv), .resp_data_o(sd), .resp_last_o(sl), .energy_inc_i(inc), .health_i(16'h0000),
        .vln_i(vln), .vll_i(vln), .iph_i(pwr), .pwr_i(pwr), .pf_i(pf), .freq_i(fr),
        .proto_modbus_o(pm), .energy_clearing_o(ec));
    dnp_master_model i_dnp_master_model (.clk_i(clk), .req_ready_i(qr), .req_valid_o(qv), .req_data_o(qd),
        .req_last_o(ql), .resp_valid_i(sv), .resp_data_i(sd), .resp_last_i(sl), .resp_ready_o(sr));
    task automatic chk(input string s, input logic [31:0] e, input logic [31:0] g);
        n_checks++;
        if (g !== e) begin
            err_count++;
            $display("unexpected %s exp %h got %h", s, e, g);
        end
    endtask : chk
    task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
        {cyc, stb, we, adr, wd} <= {2'b11, w, a, d};
        do @(posedge clk); while (ack !== 1'b1);
        q = rd;
        {cyc, stb} <= 2'b00;
        @(posedge clk);
    endtask : wb
    task automatic rq(input logic [7:0] b[$], input bit slow);
        i_dnp_master_model.tx_q = b;
        i_dnp_master_model.xfer(slow);
        n = i_dnp_master_model.rx_q.size();
    endtask : rq
    function automatic logic [15:0] r(input int k);
        return {i_dnp_master_model.rx_q[k + 1], i_dnp_master_model.rx_q[k]};
    endfunction : r
    task automatic t_bo;
        rq({8'hC0, 8'hC3, 8'h01, 8'h0A, 8'h00, 8'h06}, 1'b1);
        chk("len", 32'h0C, n);
        chk("ac fc", 16'h81C3, r(1));
        chk("iin", 16'h0080, r(3));
        chk("obj var", 16'h020A, r(5));
        chk("bo pts", 16'h8101, r(10));
        rq({8'hC0, 8'hC7, 8'h01, 8'h3C, 8'h01, 8'h06}, 1'b0);
        chk("class len", 32'h6A, n);
        chk("class ai", 16'h041E, r(5));
        chk("class cnt", 16'h0514, r(74));
        chk("class bo", 16'h020A, r(99));
        $display("end bo");
    endtask : t_bo
    task automatic t_iin;
        rq({8'hC0, 8'hC1, 8'h02, 8'h50, 8'h01, 8'h00, 8'h00, 8'h00, 8'h00}, 1'b0);
        wb(1'b0, 8'h04, 32'h0);
        chk("restart", 32'h0, q & 32'h2);
        $display("end iin");
    endtask : t_iin
    task automatic t_en;
        repeat (3) begin
            inc <= 5'h01;
            @(posedge clk);
            inc <= 5'h00;
            @(posedge clk);
        end
        rq({8'hC0, 8'hC2, 8'h01, 8'h14, 8'h00, 8'h06}, 1'b0);
        chk("cnt", 16'h0003, r(10));
        rq({8'hC0, 8'hC4, 8'h05, 8'h0C, 8'h01, 8'h17, 8'h01, 8'h00, 8'h01, 8'h01, 8'h01, 8'h00, 8'h00,
            8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00}, 1'b0);
        chk("echo", 32'h15, n);
        chk("clr", 32'h1, clr);
        rq({8'hC0, 8'hC2, 8'h01, 8'h14, 8'h00, 8'h06}, 1'b0);
        chk("cnt0", 16'h0000, r(10));
        $display("end energy");
    endtask : t_en
    task automatic t_bad;
        wb(1'b0, 8'h08, 32'h0);
        chk("rej0", 32'h0, q);
        rq({8'h80, 8'hC0, 8'h01, 8'h0A, 8'h00, 8'h06}, 1'b0);
        chk("silent", 32'h0, n);
        wb(1'b0, 8'h08, 32'h0);
        chk("rej", 32'h1, q);
        rq({8'hC0, 8'hC0, 8'h03, 8'h0A, 8'h00, 8'h06}, 1'b0);
        chk("unk", 16'h0100, r(3));
        $display("end bad");
    endtask : t_bad
    task automatic t_ai;
        wb(1'b1, 8'h00, 32'h1);
        {vln[0], pwr[0], pf, fr} <= {18'sh09C40, 18'sh07530, 16'sh01F4, 16'h1F40};
        @(posedge clk);
        rq({8'hC0, 8'hC5, 8'h01, 8'h1E, 8'h00, 8'h06}, 1'b1);
        chk("len", 32'h4A, n);
        chk("vln", 16'h7FFF, r(12));
        chk("pwr", 16'h7FFF, r(30));
        chk("pf", 16'h0000, r(36));
        chk("frq", 16'h270F, r(38));
        chk("health", 16'h0000, r(10));
        wb(1'b1, 8'hFC, 32'h0000_1234);
        wb(1'b0, 8'hFC, 32'h0);
        chk("aux31", 32'h1234, q);
        wb(1'b0, 8'h0C, 32'h0);
        chk("unmapped", 32'h0, q);
        $display("end analog");
    endtask : t_ai
    task automatic t_mb;
        rq({8'hC0, 8'hC6, 8'h06, 8'h0C, 8'h01, 8'h17, 8'h01, 8'h01, 8'h01, 8'h01, 8'h01, 8'h00, 8'h00,
            8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00}, 1'b0);
        chk("fc6 silent", 32'h0, n);
        chk("modbus", 32'h1, pm);
        rst <= 1'b1;
        @(posedge clk);
        rst <= 1'b0;
        @(posedge clk);
        chk("dnp", 32'h0, pm);
        $display("end modbus");
    endtask : t_mb
    task automatic end_sim;
        $display("checks %0d mismatches %0d", n_checks, err_count);
        if (err_count == 0 && n_checks > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask : end_sim
    initial begin
        repeat (20) @(posedge clk);
        rst <= 1'b0;
        @(posedge clk);
        t_bo();
        t_iin();
        t_en();
        t_bad();
        t_ai();
        t_mb();
        end_sim();
    end
    initial begin
        repeat (30000) @(posedge clk);
        err_count++;
        end_sim();
    end
endmodule : tb
